// file: verilog/adcc_pkg.sv
// package: register map, field positions and reset values for the converter control block
`default_nettype none
package adcc_pkg;
   // ==================================================
   // register byte offsets on the apb bus
   localparam logic [7:0] OFF_SC1 = 8'h00;
   localparam logic [7:0] OFF_SC2 = 8'h04;
   localparam logic [7:0] OFF_RH = 8'h08;
   localparam logic [7:0] OFF_RL = 8'h0C;
   localparam logic [7:0] OFF_CVH = 8'h10;
   localparam logic [7:0] OFF_CVL = 8'h14;
   localparam logic [7:0] OFF_CFG = 8'h18;
   // ==================================================
   // field positions
   localparam int SC1_CONV_COMPLETE_FLAG = 7;
   localparam int SC1_CONT = 5;
   localparam int SC2_ACT = 7;
   localparam int SC2_TRG = 6;
   localparam int SC2_CFE = 5;
   localparam int SC2_CGT = 4;
   localparam int CFG_LPC = 7;
   localparam int CFG_DIV = 5;
   localparam int CFG_LSMP = 4;
   localparam int CFG_MODE = 2;
   localparam int CFG_ICLK = 0;
   // ==================================================
   // encodings and reset values
   localparam logic [4:0] CHAN_OFF = 5'h1F;
   localparam logic [1:0] MODE_8 = 2'h0;
   localparam logic [1:0] MODE_10 = 2'h2;
   localparam logic [1:0] ICLK_BUS = 2'h0;
   localparam logic [1:0] ICLK_HALF = 2'h1;
   localparam logic [1:0] ICLK_ALT = 2'h2;
   localparam logic [1:0] ICLK_ASYNC = 2'h3;
   localparam logic [4:0] CHAN_RST = 5'h1F;
   // ==================================================
   // converter core settings carried as one group
   typedef struct packed {
      logic low_power;
      logic long_sample;
      logic [1:0] mode;
      logic [4:0] channel;
   } adcc_core_cfg_s;
   // ==================================================
   // apb request group
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } adcc_apb_req_s;
endpackage
`default_nettype wire

// file: verilog/adcc_top.sv
// converter control: triggers, compare, result interlock, clock divider and apb registers
//
// Overview of operation
// RULE1: active flag set at conversion start, cleared on completion or abort.
// RULE2: trigger select 0 starts on control-one write, 1 on hardware trigger.
// RULE3: compare enable bit switches automatic compare on or off.
// RULE4: compare sense: 0 means result below value, 1 means at or above.
// RULE5: software writes zero to the two low bits of status two.
// RULE6: result high holds top two bits; zero in 8-bit mode.
// RULE7: results load each completion unless compare on and condition false.
// RULE8: 10-bit mode: high read blocks new results until low read.
// RULE9: 8-bit mode: no interlock, results always transfer.
// RULE10: software treats results as invalid after a resolution change.
// RULE11: result low holds low eight bits, or the whole 8-bit result.
// RULE12: compare high used only in 10-bit mode, ignored in 8-bit.
// RULE13: compare low compared to low result bits in both modes.
// RULE14: low power bit selects fast or reduced-power converter setting.
// RULE15: divide select divides the chosen input clock by 1, 2, 4, 8.
// RULE16: long sample bit selects short or long sample period.
// RULE17: mode 00 is 8-bit, 10 is 10-bit, others reserved.
// RULE18: input clock select: bus, bus halved, alternate, asynchronous clock.
// RULE19: complete flag set per compare rule; cleared by control-one write or low read.
// RULE20: control-one write aborts and restarts, unless channel all ones disables.
// RULE21: hardware trigger rising edge synchronised, one conversion per assertion.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire adcc_pkg::adcc_apb_req_s apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // trigger and clock sources, sampled on mclk
   input wire logic hw_trigger_input,
   input wire logic alternate_clock,
   input wire logic async_conv_clock,
   // analog converter core
   input wire logic core_done,
   input wire logic [9:0] core_result,
   output logic core_start,
   output logic core_abort,
   output logic conv_clock,
   output adcc_pkg::adcc_core_cfg_s core_cfg,
   output logic conv_active_flag
);
   import adcc_pkg::*;

   // ==================================================
   // state
   typedef struct packed {
      logic cont;
      logic [4:0] chan;
      logic trig_sel;
      logic cmp_en;
      logic cmp_gt;
      logic [1:0] res_hi;
      logic [7:0] res_lo;
      logic [1:0] cv_hi;
      logic [7:0] cv_lo;
      logic lpc;
      logic [1:0] div;
      logic lsmp;
      logic [1:0] mode;
      logic [1:0] iclk;
      logic conv_complete_flag;
      logic active;
      logic lock;
      logic [2:0] hw_sync;
      logic [2:0] alt_sync;
      logic [2:0] ack_sync;
      logic half;
      logic [2:0] div_cnt;
      logic conv_en;
      logic start;
      logic abort;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } adcc_state_s;

   adcc_state_s s_reg;
   adcc_state_s s_next;

   // ==================================================
   // helpers
   // last count of the divider for each divide code
   function automatic logic [2:0] div_last(input logic [1:0] code);
      case (code)
         2'h0: div_last = 3'h0;
         2'h1: div_last = 3'h1;
         2'h2: div_last = 3'h3;
         default: div_last = 3'h7;
      endcase
   endfunction

   // compare condition; the high value bits only count in 10-bit mode
   function automatic logic cmp_hit(input logic [9:0] res, input logic [1:0] cvh, input logic [7:0] cvl,
                                    input logic [1:0] mode, input logic gt);
      logic [9:0] r;
      logic [9:0] v;
      r = (mode == MODE_10) ? res : {2'h0, res[7:0]};
      v = (mode == MODE_10) ? {cvh, cvl} : {2'h0, cvl}; // see RULE12 see RULE13
      cmp_hit = gt ? (r >= v) : (r < v); // see RULE4
   endfunction

   // ==================================================
   // bus decode and event terms
   logic fire;
   logic wr_fire;
   logic rd_fire;
   logic sc1_wr;
   logic rh_rd;
   logic rl_rd;
   logic enabled;
   logic hw_edge;
   logic done_ok;
   logic hit;
   logic load;
   logic in_tick;

   // a transfer acts at the edge where the master samples pready
   assign fire = apb_req.psel && apb_req.penable && s_reg.ready;
   assign wr_fire = fire && apb_req.pwrite;
   assign rd_fire = fire && !apb_req.pwrite;
   assign sc1_wr = wr_fire && (apb_req.paddr == OFF_SC1);
   assign rh_rd = rd_fire && (apb_req.paddr == OFF_RH);
   assign rl_rd = rd_fire && (apb_req.paddr == OFF_RL);
   assign enabled = (s_reg.chan != CHAN_OFF);
   // only the second and third sync stages feed the edge detector
   assign hw_edge = s_reg.hw_sync[1] && !s_reg.hw_sync[2]; // see RULE21
   // a completion in the cycle of a control-one write counts as aborted
   assign done_ok = s_reg.active && core_done && !sc1_wr;
   assign hit = cmp_hit(core_result, s_reg.cv_hi, s_reg.cv_lo, s_reg.mode, s_reg.cmp_gt);
   // interlock only exists in 10-bit mode
   assign load = done_ok && (!s_reg.cmp_en || hit) // see RULE3 see RULE7
                 && !(s_reg.lock && s_reg.mode == MODE_10); // see RULE8 see RULE9

   // input clock choice; outside clocks are sampled so only their edges count
   always_comb
   begin
      case (s_reg.iclk) // see RULE18
         ICLK_BUS: in_tick = 1'b1;
         ICLK_HALF: in_tick = s_reg.half;
         ICLK_ALT: in_tick = s_reg.alt_sync[1] && !s_reg.alt_sync[2];
         default: in_tick = s_reg.ack_sync[1] && !s_reg.ack_sync[2];
      endcase
   end

   // ==================================================
   // next state
   always_comb
   begin
      s_next = s_reg;
      s_next.start = 1'b0;
      s_next.abort = 1'b0;
      s_next.conv_en = 1'b0;
      // synchronisers and bus-clock halving
      s_next.hw_sync = {s_reg.hw_sync[1:0], hw_trigger_input};
      s_next.alt_sync = {s_reg.alt_sync[1:0], alternate_clock};
      s_next.ack_sync = {s_reg.ack_sync[1:0], async_conv_clock};
      s_next.half = !s_reg.half;
      // divider producing the conversion clock enable
      if (in_tick)
      begin
         if (s_reg.div_cnt >= div_last(s_reg.div)) // see RULE15
         begin
            s_next.div_cnt = 3'h0;
            s_next.conv_en = 1'b1;
         end
         else
         begin
            s_next.div_cnt = s_reg.div_cnt + 3'h1;
         end
      end
      // completion: results, flag and continuous restart
      if (done_ok)
      begin
         s_next.active = 1'b0; // see RULE1
         if (load)
         begin
            s_next.res_lo = core_result[7:0]; // see RULE11
            s_next.res_hi = (s_reg.mode == MODE_10) ? core_result[9:8] : 2'h0; // see RULE6
         end
         if (s_reg.cont && enabled && !s_reg.trig_sel)
         begin
            s_next.active = 1'b1;
            s_next.start = 1'b1;
         end
      end
      // hardware trigger starts one conversion per rising edge
      if (s_reg.trig_sel && hw_edge && enabled && !s_reg.active && !sc1_wr)
      begin
         s_next.active = 1'b1; // see RULE2 see RULE21
         s_next.start = 1'b1;
      end
      // interlock arms on a high read in 10-bit mode, released by a low read
      if (rh_rd && s_reg.mode == MODE_10)
      begin
         s_next.lock = 1'b1; // see RULE8
      end
      if (rl_rd)
      begin
         s_next.lock = 1'b0;
      end
      // complete flag: clear first, so a same-cycle set wins
      if (sc1_wr || rl_rd)
      begin
         s_next.conv_complete_flag = 1'b0; // see RULE19
      end
      if (done_ok && (!s_reg.cmp_en || hit))
      begin
         s_next.conv_complete_flag = 1'b1; // see RULE19
      end
      // register writes
      if (wr_fire)
      begin
         if (apb_req.paddr == OFF_SC1)
         begin
            s_next.cont = apb_req.pwdata[SC1_CONT];
            s_next.chan = apb_req.pwdata[4:0];
            s_next.abort = s_reg.active;
            s_next.active = 1'b0; // see RULE20
            s_next.start = 1'b0;
            if (apb_req.pwdata[4:0] != CHAN_OFF && !s_reg.trig_sel)
            begin
               s_next.active = 1'b1; // see RULE2 see RULE20
               s_next.start = 1'b1;
            end
         end
         else if (apb_req.paddr == OFF_SC2)
         begin
            // low two bits are reserved and not stored
            s_next.trig_sel = apb_req.pwdata[SC2_TRG];
            s_next.cmp_en = apb_req.pwdata[SC2_CFE]; // see RULE3
            s_next.cmp_gt = apb_req.pwdata[SC2_CGT];
         end
         else if (apb_req.paddr == OFF_CVH)
         begin
            s_next.cv_hi = apb_req.pwdata[1:0];
         end
         else if (apb_req.paddr == OFF_CVL)
         begin
            s_next.cv_lo = apb_req.pwdata[7:0];
         end
         else if (apb_req.paddr == OFF_CFG)
         begin
            s_next.lpc = apb_req.pwdata[CFG_LPC]; // see RULE14
            s_next.div = apb_req.pwdata[CFG_DIV +: 2];
            s_next.lsmp = apb_req.pwdata[CFG_LSMP]; // see RULE16
            s_next.mode = apb_req.pwdata[CFG_MODE +: 2]; // see RULE17
            s_next.iclk = apb_req.pwdata[CFG_ICLK +: 2];
         end
      end
      // apb answer: pready one cycle into the access phase
      s_next.ready = apb_req.psel && apb_req.penable && !s_reg.ready;
      s_next.err = 1'b0;
      s_next.rdata = 32'h0;
      if (apb_req.psel && apb_req.penable && !s_reg.ready)
      begin
         if (apb_req.paddr == OFF_SC1)
         begin
            s_next.rdata[7:0] = {s_reg.conv_complete_flag, 1'b0, s_reg.cont, s_reg.chan};
         end
         else if (apb_req.paddr == OFF_SC2)
         begin
            s_next.rdata[7:0] = {s_reg.active, s_reg.trig_sel, s_reg.cmp_en, s_reg.cmp_gt, 4'h0};
         end
         else if (apb_req.paddr == OFF_RH)
         begin
            s_next.rdata[7:0] = {6'h0, s_reg.res_hi};
         end
         else if (apb_req.paddr == OFF_RL)
         begin
            s_next.rdata[7:0] = s_reg.res_lo;
         end
         else if (apb_req.paddr == OFF_CVH)
         begin
            s_next.rdata[7:0] = {6'h0, s_reg.cv_hi};
         end
         else if (apb_req.paddr == OFF_CVL)
         begin
            s_next.rdata[7:0] = s_reg.cv_lo;
         end
         else if (apb_req.paddr == OFF_CFG)
         begin
            s_next.rdata[7:0] = {s_reg.lpc, s_reg.div, s_reg.lsmp, s_reg.mode, s_reg.iclk};
         end
         else
         begin
            s_next.err = 1'b1;
         end
      end
   end

   // ==================================================
   // state register; the channel resets to the disabled code
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.chan <= CHAN_RST;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ==================================================
   // outputs, all straight from the state register
   assign prdata = s_reg.rdata;
   assign pready = s_reg.ready;
   assign pslverr = s_reg.err;
   assign core_start = s_reg.start;
   assign core_abort = s_reg.abort;
   assign conv_clock = s_reg.conv_en;
   assign conv_active_flag = s_reg.active;
   assign core_cfg = '{low_power: s_reg.lpc, long_sample: s_reg.lsmp, mode: s_reg.mode, channel: s_reg.chan};

   // ==================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   active_on_start_a: assert property (s_reg.start |-> s_reg.active) // see RULE1
      else $error("start without active flag");
   active_clear_a: assert property (done_ok && !s_next.start |=> !s_reg.active) // see RULE1
      else $error("active flag kept after completion");
   sw_start_a: assert property (sc1_wr && apb_req.pwdata[4:0] != CHAN_OFF && !s_reg.trig_sel
                                |=> s_reg.start && s_reg.active) // see RULE2 see RULE20
      else $error("software write did not start conversion");
   disable_write_a: assert property (sc1_wr && apb_req.pwdata[4:0] == CHAN_OFF
                                     |=> !s_reg.active && !s_reg.start ##1 !s_reg.start) // see RULE20
      else $error("disabled module started conversion");
   hw_start_a: assert property (s_reg.trig_sel && hw_edge && enabled && !s_reg.active && !sc1_wr
                                |=> s_reg.start) // see RULE21
      else $error("hardware trigger missed");
   cmp_block_a: assert property (done_ok && s_reg.cmp_en && !hit
                                 |=> $stable(s_reg.res_lo) && $stable(s_reg.res_hi)) // see RULE7 see RULE4
      else $error("result loaded on false compare");
   result_load_a: assert property (done_ok && !s_reg.cmp_en && !s_reg.lock
                                   |=> s_reg.res_lo == $past(core_result[7:0])) // see RULE7 see RULE11
      else $error("result not loaded");
   hi_zero_a: assert property (load && s_reg.mode == MODE_8 |=> s_reg.res_hi == 2'h0) // see RULE6
      else $error("high result nonzero in 8-bit mode");
   interlock_hold_a: assert property (s_reg.lock && s_reg.mode == MODE_10 && done_ok
                                      |=> $stable(s_reg.res_lo)) // see RULE8
      else $error("result overwritten while locked");
   conv_complete_flag_clear_a: assert property (rl_rd && !done_ok |=> !s_reg.conv_complete_flag) // see RULE19
      else $error("complete flag not cleared by low read");
   div_pace_a: assert property (s_reg.iclk == ICLK_BUS && s_reg.div == 2'h1 && s_reg.conv_en
                                && $stable(s_reg.iclk) && $stable(s_reg.div) |=> !s_reg.conv_en) // see RULE15
      else $error("divide by two pulsed twice in a row");
   // a completion that passes the compare gate always raises the flag, even against a clear
   conv_complete_flag_set_a: assert property (done_ok && (!s_reg.cmp_en || hit) |=> s_reg.conv_complete_flag) // see RULE19
      else $error("complete flag not set");
   lock_arm_a: assert property (rh_rd && s_reg.mode == MODE_10 |=> s_reg.lock) // see RULE8
      else $error("high read did not lock results");
   abort_pulse_a: assert property (sc1_wr && s_reg.active |=> s_reg.abort) // see RULE20 see RULE1
      else $error("write during conversion did not abort");
   // with the hardware trigger chosen, only a synchronised edge may start
   hw_only_start_a: assert property (s_reg.trig_sel && !hw_edge |=> !s_reg.start) // see RULE2 see RULE21
      else $error("start without trigger edge");
   sw_only_start_a: assert property (!s_reg.trig_sel && !sc1_wr && !done_ok |=> !s_reg.start) // see RULE2
      else $error("start without software write");
endmodule // adcc_top
`default_nettype wire

// file: sim/adcc_core_model.sv
// converter core stand-in: answers a start with a done pulse after a set delay, unless an abort or a new start comes first
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // requests from the control block
   input wire logic core_start,
   input wire logic core_abort,
   // what to return, and after how many cycles
   input wire logic [9:0] next_result,
   input wire logic [7:0] delay,
   // answer
   output logic core_done,
   output logic [9:0] core_result
);
   logic [7:0] left_reg;
   logic busy_reg;
   // ==================================================
   // count down; result lines only hold data with done, so they toggle otherwise
   always_ff @(posedge mclk)
   begin
      core_done <= 1'b0;
      core_result <= ~core_result;
      if (rst)
      begin
         busy_reg <= 1'b0;
         left_reg <= 8'h00;
         core_result <= 10'h155;
      end
      else if (core_start)
      begin
         busy_reg <= 1'b1;
         left_reg <= delay;
      end
      else if (core_abort)
         busy_reg <= 1'b0;
      else if (busy_reg && left_reg == 8'h01)
      begin
         busy_reg <= 1'b0;
         core_done <= 1'b1;
         core_result <= next_result;
      end
      else if (busy_reg)
         left_reg <= left_reg - 8'h01;
   end
endmodule // adcc_core_model
`default_nettype wire

// file: sim/tb_top.sv
// testbench: apb register tests, conversions, compare, interlock, triggers, clock divide
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import adcc_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   adcc_apb_req_s req = '0;
   logic [31:0] prdata;
   logic pready, pslverr, done, start, abort_p, cclk, active, last_err;
   logic hw = 1'b0;
   logic alt = 1'b0;
   logic asy = 1'b0;
   logic [9:0] cres, res = 10'h000;
   logic [7:0] sc = 8'h00;
   logic [7:0] exp_rl;
   logic [7:0] cfg_val;
   adcc_core_cfg_s cfg;
   int error_cnt = 0;
   int compares = 0;
   int start_cnt = 0;
   int abort_cnt = 0;
   int tick_cnt = 0;
   int s0;
   logic [7:0] offs [7] = '{OFF_SC1, OFF_SC2, OFF_RH, OFF_RL, OFF_CVH, OFF_CVL, OFF_CFG};
   // mode10, gt, cvh, cvl, result, hit
   logic [22:0] cases [6] = '{{1'b1, 1'b0, 2'h2, 8'h00, 10'h1FF, 1'b1}, {1'b1, 1'b0, 2'h2, 8'h00, 10'h200, 1'b0},
      {1'b1, 1'b1, 2'h2, 8'h00, 10'h200, 1'b1}, {1'b1, 1'b1, 2'h2, 8'h00, 10'h1FF, 1'b0},
      {1'b0, 1'b1, 2'h3, 8'h80, 10'h080, 1'b1}, {1'b0, 1'b0, 2'h3, 8'h80, 10'h080, 1'b0}};
   adcc_top dut (.mclk(mclk), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hw_trigger_input(hw), .alternate_clock(alt), .async_conv_clock(asy), .core_done(done),
      .core_result(cres), .core_start(start), .core_abort(abort_p), .conv_clock(cclk), .core_cfg(cfg),
      .conv_active_flag(active));
   adcc_core_model core (.mclk(mclk), .rst(rst), .core_start(start), .core_abort(abort_p), .next_result(res),
      .delay(8'h14), .core_done(done), .core_result(cres));
   // ==================================================
   // clock, slow clock sources of period 4 and 8, pulse counters on the quiet edge
   always #20 mclk = ~mclk;
   always @(posedge mclk)
   begin
      sc <= sc + 8'h01;
      alt <= sc[1];
      asy <= sc[2];
   end
   always @(negedge mclk)
   begin
      start_cnt += int'(start);
      abort_cnt += int'(abort_p);
      tick_cnt += int'(cclk);
   end
   // ==================================================
   task automatic close_out();
      $display("compares %0d, error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; access held until pready is seen high at a rising edge, data taken there
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
      @(posedge mclk);
      req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         close_out();
      end
      q = prdata;
      last_err = pslverr;
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      apb(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   // software start, check the busy view, then wait for the end of conversion
   task automatic conv(input logic [9:0] r, input logic [7:0] sc2);
      int n;
      res <= r;
      s0 = start_cnt;
      wr(OFF_SC1, 8'h01);
      @(posedge mclk);
      chk(start_cnt - s0, 1);
      chk(active, 1'b1);
      rc(OFF_SC2, {24'h0, sc2 | 8'h80});
      for (n = 0; n < 200 && active !== 1'b0; n++)
         @(negedge mclk);
      chk(n < 200, 1'b1);
   endtask
   // ==================================================
   initial
   begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      foreach (offs[i]) rc(offs[i], i == 0 ? 32'h1F : 32'h0);
      rc(8'h1C, 32'h0);
      chk(last_err, 1'b1);
      wr(OFF_RL, 8'h55);
      rc(OFF_RL, 32'h0);
      wr(OFF_CVH, 8'hFF);
      rc(OFF_CVH, 32'h3);
      // walking one through configuration bits 7 down to 1, read back over the bus
      foreach (offs[i])
      begin
         wr(OFF_CFG, 8'h80 >> i);
         rc(OFF_CFG, {24'h0, 8'h80 >> i});
      end
      // fields reach the core pins at the write edge itself, checked one cycle later
      foreach (offs[i])
      begin
         cfg_val = 8'h94 >> i;
         wr(OFF_CFG, cfg_val);
         @(posedge mclk);
         chk({28'h0, cfg.low_power, cfg.long_sample, cfg.mode}, {28'h0, cfg_val[7], cfg_val[4], cfg_val[3:2]});
      end
      // divide ratio and source period both scale the tick spacing by powers of two
      for (int i = 0; i < 16; i++)
      begin
         wr(OFF_CFG, {1'b0, i[1:0], 3'b000, i[3:2]});
         repeat (70) @(posedge mclk);
         s0 = tick_cnt;
         repeat (64) @(posedge mclk);
         chk(tick_cnt - s0, 64 >> (int'(i[1:0]) + int'(i[3:2])));
      end
      wr(OFF_CFG, {4'h0, MODE_10, 2'h0});
      wr(OFF_SC2, 8'h00);
      conv(10'h2A5, 8'h00);
      chk(cfg.channel, 5'h01);
      rc(OFF_SC1, 32'h81);
      rc(OFF_RH, 32'h2);
      rc(OFF_RL, 32'hA5);
      rc(OFF_SC1, 32'h01);
      conv(10'h1C3, 8'h00);
      rc(OFF_RH, 32'h1);
      conv(10'h3FF, 8'h00);
      rc(OFF_RL, 32'hC3);
      conv(10'h0F0, 8'h00);
      rc(OFF_RH, 32'h0);
      rc(OFF_RL, 32'hF0);
      wr(OFF_CFG, {4'h0, MODE_8, 2'h0});
      conv(10'h0C7, 8'h00);
      rc(OFF_RH, 32'h0);
      conv(10'h055, 8'h00);
      rc(OFF_RL, 32'h55);
      exp_rl = 8'h55;
      foreach (cases[i])
      begin
         wr(OFF_CFG, {4'h0, cases[i][22], 3'h0});
         wr(OFF_CVH, {6'h0, cases[i][20:19]});
         wr(OFF_CVL, cases[i][18:11]);
         wr(OFF_SC2, {2'b00, 1'b1, cases[i][21], 4'h0});
         conv(cases[i][10:1], {2'b00, 1'b1, cases[i][21], 4'h0});
         rc(OFF_SC1, {24'h0, cases[i][0], 7'h01});
         if (cases[i][0])
            exp_rl = cases[i][8:1];
         rc(OFF_RL, {24'h0, exp_rl});
      end
      wr(OFF_SC2, 8'h40);
      s0 = start_cnt;
      wr(OFF_SC1, 8'h01);
      repeat (3) @(negedge mclk);
      chk(start_cnt - s0, 0);
      @(posedge mclk);
      res <= 10'h012;
      hw <= 1'b1;
      repeat (5) @(negedge mclk);
      chk(active, 1'b1);
      repeat (40) @(posedge mclk);
      chk(start_cnt - s0, 1);
      hw <= 1'b0;
      rc(OFF_RL, 32'h12);
      wr(OFF_SC2, 8'h00);
      s0 = abort_cnt;
      wr(OFF_SC1, 8'h01);
      wr(OFF_SC1, 8'h01);
      @(posedge mclk);
      chk(abort_cnt - s0, 1);
      chk(active, 1'b1);
      wr(OFF_SC1, 8'h1F);
      @(negedge mclk);
      chk(active, 1'b0);
      repeat (30) @(posedge mclk);
      rc(OFF_SC1, 32'h1F);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
